// >>> design/bms_defines.svh
// How it works
// - reset mode clears state; low supply forces reset
// - supply good releases reset into standby
// - standby while request low, pwm idle, supply good
// - settings written in standby apply after startup
// - request or pwm high starts startup
// - startup holds a fixed 2 ms delay
// - thermal shutdown holds device in startup
// - soft start lasts 4 ms, leds off
// - soft start only when boost enable high
// - settings may change freely in normal mode
// - state timing runs on 5 MHz tick
// - pwm clock multiplies the 5 MHz tick
// - pwm clock may follow sync, up to 55 kHz
// - 13-bit divider sets ticks per sync period
// - internal clock used until sync lock
// - two-bit source select: duty, level, direct
// - faults shown in status and fault pin
// - temperature trip halves brightness in duty and level modes, not in direct mode
// - open and short led faults detected
// - direct mode resamples pwm input to outputs
// - level mode uses 8-bit brightness level
// - pwm low 50 ms returns to standby when request is low
`ifndef BMS_DEFINES_SVH
`define BMS_DEFINES_SVH
`define BMS_SYS_MHZ 100
`define BMS_OSC_MHZ 5
`define BMS_STARTUP_US 2000
`define BMS_SOFTSTART_US 4000
`define BMS_OFF_US 50000
`define BMS_SYNC_MAX_KHZ 55
`define BMS_SRC_LEVEL 2'h2
`define BMS_SRC_DIRECT 2'h3
`define BMS_LEDS 6
`endif

// >>> design/bms_pkg.sv
package bms_pkg;
   typedef enum logic [2:0] {
      bms_reset,
      bms_standby,
      bms_startup,
      bms_soft_start,
      bms_normal
   } bms_state_type;
endpackage

// >>> design/bms_sequencer.sv
`timescale 1ns/1ps
`include "bms_defines.svh"
module bms_sequencer import bms_pkg::*; #(
   parameter int STARTUP_TICKS = `BMS_STARTUP_US * `BMS_OSC_MHZ,
   parameter int SOFTSTART_TICKS = `BMS_SOFTSTART_US * `BMS_OSC_MHZ,
   parameter int OFF_TICKS = `BMS_OFF_US * `BMS_OSC_MHZ,
   parameter int LEDS = `BMS_LEDS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // pins from outside
   input wire logic regulator_supply,
   input wire logic pwm_in,
   input wire logic thermal_shutdown,
   input wire logic sync_in,
   input wire logic [LEDS-1:0] led_open,
   input wire logic [LEDS-1:0] led_short,
   // control settings
   input wire logic backlight_on_request,
   input wire logic boost_enable,
   input wire logic [1:0] brightness_source_select,
   input wire logic [7:0] brightness_level,
   input wire logic [1:0] pwm_clock_multiplier,
   input wire logic sync_enable,
   input wire logic [12:0] pll_divider,
   input wire logic [7:0] temperature,
   input wire logic [7:0] temperature_limit,
   input wire logic fault_clear,
   // status
   output logic [2:0] mode,
   output logic boost_on,
   output logic boost_soft_start,
   output logic [LEDS-1:0] led_drive,
   output logic pll_locked,
   output logic [2*LEDS:0] fault_status,
   output logic fault_pin_out,
   output logic fault_pin_oe
);
   localparam int NSYNC = 4 + 2 * LEDS;
   localparam int DIVW = 5;
   localparam logic [DIVW-1:0] OSC_DIV = DIVW'(`BMS_SYS_MHZ / `BMS_OSC_MHZ - 1);
   localparam logic [7:0] ACC_MOD = 8'(`BMS_SYS_MHZ);
   localparam logic [23:0] SYNC_MIN = 24'(`BMS_SYS_MHZ * 1000 / `BMS_SYNC_MAX_KHZ);

   // two-flop synchronisers
   logic [NSYNC-1:0] meta;
   logic [NSYNC-1:0] sync;
   wire [NSYNC-1:0] raw = {led_short, led_open, sync_in, thermal_shutdown, pwm_in,
      regulator_supply};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               meta[gi] <= 1'b0;
               sync[gi] <= 1'b0;
            end else begin
               meta[gi] <= raw[gi];
               sync[gi] <= meta[gi];
            end
         end
      end
   endgenerate
   wire supply_ok = sync[0];
   wire pwm_s = sync[1];
   wire tsd_s = sync[2];
   wire vsync_s = sync[3];
   wire [2*LEDS-1:0] led_fault_s = sync[NSYNC-1:4];

   bms_state_type state;
   bms_state_type next_state;
   logic [DIVW-1:0] osc_cnt;
   logic [17:0] timer;
   logic [17:0] low_timer;
   logic [7:0] win_cnt;
   logic [7:0] high_cnt;
   logic [7:0] duty_meas;
   logic [7:0] pwm_acc;
   logic [23:0] sync_period;
   logic [23:0] sync_cnt;
   logic [24:0] sync_acc;
   logic [1:0] sync_edges;
   logic vsync_d;
   logic [7:0] pwm_cnt;

   // 5 MHz state machine tick
   wire osc_tick = (osc_cnt == OSC_DIV);
   wire in_reset = (state == bms_reset);
   wire in_normal = (state == bms_normal);
   wire start_req = backlight_on_request | pwm_s;
   wire startup_done = (timer >= 18'(STARTUP_TICKS - 1)) && osc_tick;
   wire soft_done = (timer >= 18'(SOFTSTART_TICKS - 1)) && osc_tick;
   wire off_done = (low_timer >= 18'(OFF_TICKS - 1)) && osc_tick;

   always_comb begin
      next_state = state;
      case (state)
         bms_reset: begin
            if (supply_ok) next_state = bms_standby;
         end
         bms_standby: begin
            if (start_req) next_state = bms_startup;
         end
         bms_startup: begin
            if (!tsd_s && startup_done) begin
               next_state = boost_enable ? bms_soft_start : bms_normal;
            end
         end
         bms_soft_start: begin
            if (tsd_s) next_state = bms_startup;
            else if (soft_done) next_state = bms_normal;
         end
         bms_normal: begin
            if (tsd_s) next_state = bms_startup;
            else if (!backlight_on_request && off_done) next_state = bms_standby;
         end
         default: next_state = bms_reset;
      endcase
      if (!supply_ok) next_state = bms_reset;
   end

   wire state_change = (next_state != state);
   wire [17:0] next_timer = (state_change || (state == bms_startup && tsd_s)) ? 18'h00000 :
      (osc_tick ? timer + 18'h00001 : timer);
   wire [17:0] next_low_timer = (pwm_s || !in_normal) ? 18'h00000 :
      ((osc_tick && !off_done) ? low_timer + 18'h00001 : low_timer);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= bms_reset;
         osc_cnt <= '0;
         timer <= 18'h00000;
         low_timer <= 18'h00000;
      end else begin
         state <= next_state;
         osc_cnt <= osc_tick ? '0 : osc_cnt + 1'b1;
         timer <= next_timer;
         low_timer <= next_low_timer;
      end
   end

   // input duty measured over a 255-tick window
   wire win_end = (win_cnt == 8'hFE);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         win_cnt <= 8'h00;
         high_cnt <= 8'h00;
         duty_meas <= 8'h00;
      end else if (in_reset) begin
         win_cnt <= 8'h00;
         high_cnt <= 8'h00;
         duty_meas <= 8'h00;
      end else if (osc_tick) begin
         win_cnt <= win_end ? 8'h00 : win_cnt + 8'h01;
         high_cnt <= win_end ? 8'h00 : high_cnt + {7'h00, pwm_s};
         if (win_end) duty_meas <= high_cnt + {7'h00, pwm_s};
      end
   end

   // internal pwm clock: 5 MHz times 1, 2, 4 or 8
   wire [7:0] acc_step = 8'(`BMS_OSC_MHZ) << pwm_clock_multiplier;
   wire [8:0] acc_sum = {1'b0, pwm_acc} + {1'b0, acc_step};
   wire int_tick = (acc_sum >= {1'b0, ACC_MOD});
   wire [8:0] acc_wrap = acc_sum - {1'b0, ACC_MOD};

   // sync-following clock: divider ticks per sync period
   wire sync_edge = vsync_s && !vsync_d;
   wire sync_valid = sync_edge && (sync_cnt >= SYNC_MIN);
   wire [24:0] sync_sum = sync_acc + {12'h000, pll_divider};
   wire sync_tick = pll_locked && (sync_sum >= {1'b0, sync_period});
   wire [24:0] sync_wrap = sync_sum - {1'b0, sync_period};
   wire use_sync = sync_enable && pll_locked;
   wire pwm_tick = use_sync ? sync_tick : int_tick;
   wire pll_run = sync_enable && !in_reset && state != bms_standby;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pwm_acc <= 8'h00;
         vsync_d <= 1'b0;
         sync_cnt <= 24'h000000;
         sync_period <= 24'h000000;
         sync_acc <= 25'h0000000;
         sync_edges <= 2'h0;
         pll_locked <= 1'b0;
      end else begin
         pwm_acc <= int_tick ? acc_wrap[7:0] : acc_sum[7:0];
         vsync_d <= vsync_s;
         if (!pll_run) begin
            sync_cnt <= 24'h000000;
            sync_acc <= 25'h0000000;
            sync_edges <= 2'h0;
            pll_locked <= 1'b0;
         end else begin
            if (sync_valid) sync_cnt <= 24'h000000;
            else if (sync_cnt != 24'hFFFFFF) sync_cnt <= sync_cnt + 24'h000001;
            if (sync_valid) sync_period <= sync_cnt;
            if (sync_valid && sync_edges != 2'h3) sync_edges <= sync_edges + 2'h1;
            pll_locked <= (sync_edges >= 2'h2);
            if (!pll_locked) sync_acc <= 25'h0000000;
            else sync_acc <= sync_tick ? sync_wrap : sync_sum;
         end
      end
   end

   // brightness source and thermal derating
   wire derate = (temperature >= temperature_limit);
   wire [7:0] src_duty = (brightness_source_select == `BMS_SRC_LEVEL) ? brightness_level :
      duty_meas;
   wire [7:0] eff_duty = derate ? {1'b0, src_duty[7:1]} : src_duty;
   wire cmp_out = (pwm_cnt < eff_duty);
   wire direct = (brightness_source_select == `BMS_SRC_DIRECT);
   logic direct_q;
   // leds only in normal mode; settings are read live there
   wire led_on = in_normal && !tsd_s;
   wire [LEDS-1:0] next_led = led_on ? {LEDS{direct ? direct_q : cmp_out}} : '0;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pwm_cnt <= 8'h00;
         direct_q <= 1'b0;
         led_drive <= '0;
      end else begin
         if (pwm_tick) pwm_cnt <= (pwm_cnt == 8'hFE) ? 8'h00 : pwm_cnt + 8'h01;
         if (pwm_tick) direct_q <= pwm_s;
         led_drive <= next_led;
      end
   end

   // sticky faults: set wins over clear
   wire [2*LEDS:0] fault_set = in_normal ? {tsd_s, led_fault_s} : {tsd_s, {2*LEDS{1'b0}}};
   wire [2*LEDS:0] next_fault = fault_set | (fault_clear ? '0 : fault_status);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode <= 3'h0;
         boost_on <= 1'b0;
         boost_soft_start <= 1'b0;
         fault_status <= '0;
         fault_pin_out <= 1'b0;
         fault_pin_oe <= 1'b0;
      end else begin
         mode <= next_state;
         boost_on <= !tsd_s && (next_state == bms_normal || next_state == bms_soft_start) &&
            boost_enable;
         boost_soft_start <= !tsd_s && next_state == bms_soft_start;
         fault_status <= in_reset ? '0 : next_fault;
         fault_pin_out <= 1'b0;
         fault_pin_oe <= !in_reset && (|next_fault);
      end
   end
endmodule // bms_sequencer

// >>> verif/bms_sequencer_monitor.sv
`timescale 1ns/1ps
module bms_sequencer_monitor import bms_pkg::*; #(
   parameter int STARTUP_TICKS = 4,
   parameter int SOFTSTART_TICKS = 8,
   parameter int LEDS = 6
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // inputs
   input wire logic regulator_supply,
   input wire logic pwm_in,
   input wire logic thermal_shutdown,
   input wire logic backlight_on_request,
   input wire logic boost_enable,
   input wire logic [1:0] brightness_source_select,
   // outputs
   input wire logic [2:0] mode,
   input wire logic boost_on,
   input wire logic [LEDS-1:0] led_drive,
   input wire logic [2*LEDS:0] fault_status,
   input wire logic fault_pin_oe
);
   logic [2:0] prev;
   int cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // cycles spent in the current mode
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prev <= 3'h0;
         cnt <= 0;
      end else begin
         prev <= mode;
         cnt <= (mode != prev) ? 0 : cnt + 1;
      end
   end
   a_supply_low: assert property (!regulator_supply |-> ##[1:4] mode == 3'h0)
      else $error("mode stayed up with supply low");
   a_standby_hold: assert property ((mode == 3'h1 && !backlight_on_request && !pwm_in)[*4]
      |=> mode inside {3'h0, 3'h1}) else $error("standby left while idle");
   a_start_req: assert property (mode == 3'h1 && backlight_on_request && regulator_supply
      |=> mode == 3'h2) else $error("request did not start");
   a_startup_len: assert property (prev == 3'h2 && mode inside {3'h3, 3'h4}
      |-> cnt >= (STARTUP_TICKS - 1) * 20 - 1) else $error("startup too short");
   a_soft_len: assert property (prev == 3'h3 && mode == 3'h4
      |-> cnt >= (SOFTSTART_TICKS - 1) * 20 - 1) else $error("soft start too short");
   a_boost_choice: assert property (prev == 3'h2 && mode inside {3'h3, 3'h4}
      |-> (mode == 3'h3) == boost_enable) else $error("wrong exit from startup");
   a_leds_dark: assert property (mode != 3'h4 && prev != 3'h4 && $past(mode, 2) != 3'h4
      |-> led_drive == '0) else $error("leds lit outside normal");
   a_direct_follow: assert property ($rose(pwm_in) && mode == 3'h4 && !thermal_shutdown
      && brightness_source_select == 2'h3 |-> ##[2:30] led_drive[0])
      else $error("direct output did not follow");
   a_thermal_off: assert property (thermal_shutdown[*8] |-> !boost_on && led_drive == '0)
      else $error("power stage on in overtemp");
   a_fault_pin: assert property (fault_status != '0 |-> ##[0:2] fault_pin_oe)
      else $error("fault pin not pulled");
endmodule // bms_sequencer_monitor
bind bms_sequencer bms_sequencer_monitor #(.STARTUP_TICKS(STARTUP_TICKS),
   .SOFTSTART_TICKS(SOFTSTART_TICKS), .LEDS(LEDS)) i_mon (.clk_sys(clk_sys),
   .reset_n(reset_n), .regulator_supply(regulator_supply), .pwm_in(pwm_in),
   .thermal_shutdown(thermal_shutdown), .backlight_on_request(backlight_on_request),
   .boost_enable(boost_enable), .brightness_source_select(brightness_source_select),
   .mode(mode), .boost_on(boost_on), .led_drive(led_drive), .fault_status(fault_status),
   .fault_pin_oe(fault_pin_oe));

// >>> verif/bms_host_model.sv
`timescale 1ns/1ps
module bms_host_model (
   // clock and control
   input wire logic clk_sys,
   input wire logic enable,
   input wire logic [7:0] high_cycles,
   // pin
   output logic pwm_in
);
   logic [7:0] phase = 8'h00;
   initial pwm_in = 1'b0;
   // 200-cycle period; idle low while enable is low
   always @(negedge clk_sys) begin
      phase <= (phase == 8'hC7) ? 8'h00 : phase + 8'h01;
      pwm_in <= enable && (phase < high_cycles);
   end
endmodule // bms_host_model

// >>> verif/tb_bms_sequencer.sv
`timescale 1ns/1ps
module tb_bms_sequencer;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic regulator_supply = 1'b1;
   logic thermal_shutdown = 1'b0;
   logic host_en = 1'b0;
   logic backlight_on_request = 1'b0;
   logic boost_enable = 1'b1;
   logic [1:0] brightness_source_select = 2'h2;
   logic [7:0] brightness_level = 8'h00;
   logic [1:0] pwm_clock_multiplier = 2'h0;
   logic [7:0] temperature = 8'h00;
   logic [7:0] host_high = 8'h64;
   logic [5:0] led_open = 6'h00;
   logic [5:0] led_short = 6'h00;
   logic fault_clear = 1'b0;
   logic [7:0] temperature_limit = 8'hFF;
   logic boost_soft_start;
   logic pwm_in;
   logic [2:0] mode;
   logic boost_on;
   logic [5:0] led_drive;
   logic [12:0] fault_status;
   logic fault_pin_oe;
   int seed = 86;
   int err_count = 0;
   int compares = 0;
   int n;
   int idx;
   always #5 clk_sys = ~clk_sys;
   bms_host_model i_host (.clk_sys(clk_sys), .enable(host_en), .high_cycles(host_high),
      .pwm_in(pwm_in));
   bms_sequencer #(.STARTUP_TICKS(4), .SOFTSTART_TICKS(8), .OFF_TICKS(16)) i_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .regulator_supply(regulator_supply),
      .pwm_in(pwm_in), .thermal_shutdown(thermal_shutdown), .sync_in(1'b0),
      .led_open(led_open), .led_short(led_short),
      .backlight_on_request(backlight_on_request), .boost_enable(boost_enable),
      .brightness_source_select(brightness_source_select),
      .brightness_level(brightness_level), .pwm_clock_multiplier(pwm_clock_multiplier),
      .sync_enable(1'b0), .pll_divider(13'h0000), .temperature(temperature),
      .temperature_limit(temperature_limit), .fault_clear(fault_clear), .mode(mode),
      .boost_on(boost_on), .boost_soft_start(boost_soft_start), .led_drive(led_drive),
      .pll_locked(),
      .fault_status(fault_status), .fault_pin_out(), .fault_pin_oe(fault_pin_oe));
   function automatic int min_cycles(input int ticks);
      return (ticks - 1) * 20 - 2;
   endfunction
   task automatic print_verdict();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         err_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask
   task automatic wait_mode(input logic [2:0] m, input int lim);
      n = 0;
      while (mode !== m && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      check(mode, m);
      if (mode !== m) print_verdict();
   endtask
   task automatic count_leds(input int cyc);
      n = 0;
      repeat (cyc) begin
         @(negedge clk_sys);
         n += (led_drive[0] === 1'b1);
      end
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      reset_n = 1'b1;
      wait_mode(3'h1, 10);
      repeat (20) @(negedge clk_sys);
      check(mode, 3'h1);
      backlight_on_request = 1'b1;
      @(negedge clk_sys);
      check(mode, 3'h2);
      wait_mode(3'h3, 200);
      check(n >= min_cycles(4), 1'b1);
      check(boost_soft_start, 1'b1);
      wait_mode(3'h4, 400);
      check(n >= min_cycles(8), 1'b1);
      count_leds(600);
      check(n, 0);
      brightness_level = 8'h80 | 8'($random(seed));
      count_leds(6000);
      check(n > 0, 1'b1);
      host_en = 1'b1;
      temperature = 8'($random(seed)) & 8'h7F;
      for (int c = 0; c < 2; c++) begin
         brightness_source_select = 2'(c);
         count_leds(6000);
         count_leds(10240);
         check(n > 3584 && n < 6656, 1'b1);
      end
      brightness_source_select = 2'h3;
      host_high = 8'(20 * (1 + {$random(seed)} % 7));
      count_leds(600);
      check(n >= 3 * host_high - 20 && n <= 3 * host_high + 20, 1'b1);
      check(led_drive === {6{led_drive[0]}}, 1'b1);
      idx = {$random(seed)} % 6;
      led_open = 6'h01 << idx;
      repeat (10) @(negedge clk_sys);
      check(fault_status, 13'h0001 << idx);
      check(fault_pin_oe, 1'b1);
      led_open = 6'h00;
      fault_clear = 1'b1;
      repeat (5) @(negedge clk_sys);
      fault_clear = 1'b0;
      check(fault_status, 13'h0000);
      thermal_shutdown = 1'b1;
      boost_enable = 1'b0;
      repeat (200) @(negedge clk_sys);
      check(mode, 3'h2);
      check({boost_on, led_drive}, 7'h00);
      check(fault_status[12], 1'b1);
      thermal_shutdown = 1'b0;
      wait_mode(3'h4, 200);
      host_en = 1'b0;
      backlight_on_request = 1'b0;
      wait_mode(3'h1, 400);
      check(n >= min_cycles(16), 1'b1);
      regulator_supply = 1'b0;
      repeat (6) @(negedge clk_sys);
      check({mode, fault_status}, 16'h0000);
      regulator_supply = 1'b1;
      wait_mode(3'h1, 10);
      print_verdict();
   end
endmodule // tb_bms_sequencer
